// File: bench/rscr_regs_checker.sv
// concurrent checks on the ports of the sync, format and channel register bank
// assumes it is bound into rscr_regs and runs on core_clk_i with rst_i synchronous
`timescale 1ns/100ps
`default_nettype none
module rscr_regs_checker
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic wr_en_i,
   input wire logic rd_en_i,
   input wire logic [9:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic [7:0] rdata_o,
   input wire logic rd_valid_o,
   input wire logic [23:0] sync_pattern_o,
   input wire logic [4:0] sync_len_o,
   input wire logic [1:0] sync_tol_o,
   input wire logic sync_detect_en_o,
   input wire logic preamble_detect_en_o,
   input wire logic preamble_qual_en_o,
   input wire logic [3:0] preamble_err_allow_o,
   input wire logic agc_lock_after_preamble_o,
   input wire logic [7:0] frame_format_code_o,
   input wire logic fsk_mode_o,
   input wire logic [23:0] channel_tuning_word_o,
   input wire logic [5:0] tx_deviation_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);
   // decoded writes, kept apart so the properties stay short
   logic wr_fmt;
   logic wr_sync;
   logic wr_dev;
   assign wr_fmt = wr_en_i && addr_i == rscr_pkg::PACKET_FORMAT_SELECT_ADDR;
   assign wr_sync = wr_en_i && addr_i == rscr_pkg::SYNC_MATCH_SETUP_ADDR;
   assign wr_dev = wr_en_i && addr_i == rscr_pkg::TRANSMIT_DEVIATION_SETTING_ADDR;
   property p_rd_pulse; 1 |=> rd_valid_o == $past(rd_en_i); endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("read valid not one cycle after strobe");
   property p_fmt_wr; wr_fmt |=> frame_format_code_o == $past(wdata_i); endproperty
   a_fmt_wr: assert property (p_fmt_wr) else $error("format code not captured");
   property p_fsk; 1 |-> fsk_mode_o == ($past(frame_format_code_o) inside {8'h03, 8'h04}); endproperty
   a_fsk: assert property (p_fsk) else $error("fsk flag wrong for format");
   property p_len_off; sync_len_o == 5'h00 |-> !sync_detect_en_o; endproperty
   a_len_off: assert property (p_len_off) else $error("sync detect on with zero length");
   property p_qual; preamble_qual_en_o |-> preamble_detect_en_o; endproperty
   a_qual: assert property (p_qual) else $error("qualification without detection");
   property p_agc; agc_lock_after_preamble_o |-> fsk_mode_o; endproperty
   a_agc: assert property (p_agc) else $error("gain lock outside fsk formats");
   property p_sync_wr; wr_sync |=> ##1 {sync_tol_o, sync_len_o} == $past(wdata_i[6:0], 2); endproperty
   a_sync_wr: assert property (p_sync_wr) else $error("tolerance or length not passed on");
   property p_dev_wr; wr_dev |=> ##1 tx_deviation_o == $past(wdata_i[5:0], 2); endproperty
   a_dev_wr: assert property (p_dev_wr) else $error("deviation not passed on");
   c_read: cover property (rd_valid_o);
   c_fsk: cover property (fsk_mode_o);
   c_agc: cover property (agc_lock_after_preamble_o);
endmodule
bind rscr_regs rscr_regs_checker u_chk (.*);
`default_nettype wire

// File: bench/rscr_regs_test.sv
// self-checking bench for the sync, format and channel register bank
// assumes the checker is bound separately; reads are scored from a queue of notes
`timescale 1ns/100ps
`default_nettype none
module rscr_regs_test;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wr_en_i = 1'b0;
   logic rd_en_i = 1'b0;
   logic [9:0] addr_i = 10'h000;
   logic [7:0] wdata_i = 8'h00;
   logic [7:0] rdata_o;
   logic rd_valid_o;
   logic [23:0] sync_pattern_o;
   logic [4:0] sync_len_o;
   logic [1:0] sync_tol_o;
   logic sync_detect_en_o;
   logic preamble_detect_en_o;
   logic preamble_qual_en_o;
   logic [3:0] preamble_err_allow_o;
   logic agc_lock_after_preamble_o;
   logic [7:0] frame_format_code_o;
   logic fsk_mode_o;
   logic [23:0] channel_tuning_word_o;
   logic [5:0] tx_deviation_o;
   int n_mismatch = 0;
   int checks_done = 0;
   logic [7:0] exp_q[$];
   logic [9:0] adr[10] = '{10'h10c, 10'h10d, 10'h10e, 10'h10f, 10'h111, 10'h13e, 10'h300, 10'h301, 10'h302, 10'h304};
   logic [7:0] rst_v[10] = '{8'h31, 8'h7a, 8'haa, 8'h18, 8'h0b, 8'h00, 8'h80, 8'ha9, 8'h03, 8'h32};
   logic [7:0] msk[10] = '{8'hff, 8'hff, 8'hff, 8'h7f, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f};
   logic [7:0] shadow[10];
   logic [7:0] dev_rec[4] = '{8'h32, 8'h06, 8'h0d, 8'h19};
   rscr_regs dut (.*);
   initial
   begin
      forever #50 core_clk_i = ~core_clk_i;
   end
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // read data is settled by the falling edge, so no race with the launching edge
   always @(negedge core_clk_i)
   begin
      if (rd_valid_o === 1'b1)
      begin
         if (exp_q.size() == 0)
         begin
            n_mismatch++;
            $display("FAIL %0t read data with no expectation", $time);
         end
         else
            chk(rdata_o, exp_q.pop_front());
      end
   end
   // strobes stay up across back-to-back calls; idle drops them
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      rd_en_i = 1'b0;
      wr_en_i = 1'b1;
      addr_i = a;
      wdata_i = d;
      @(posedge core_clk_i);
      #1;
   endtask
   task automatic rd(input logic [9:0] a, input logic [7:0] e);
      wr_en_i = 1'b0;
      rd_en_i = 1'b1;
      addr_i = a;
      exp_q.push_back(e);
      @(posedge core_clk_i);
      #1;
   endtask
   task automatic idle(input int n);
      wr_en_i = 1'b0;
      rd_en_i = 1'b0;
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   initial
   begin
      void'($urandom(53389));
      repeat (16) @(posedge core_clk_i);
      #1;
      rst_i = 1'b0;
      // reset values, read back to back
      for (int i = 0; i < 10; i++)
         rd(adr[i], rst_v[i]);
      idle(2);
      chk(sync_pattern_o, 24'haa7a31);
      chk(channel_tuning_word_o, 24'h03a980);
      chk({sync_tol_o, sync_len_o, tx_deviation_o}, {2'h0, 5'h18, 6'h32});
      chk({preamble_detect_en_o, preamble_qual_en_o, preamble_err_allow_o}, {2'h3, 4'h1});
      // random fill, reserved bits must stay at reset, unmapped place ignored
      for (int i = 0; i < 10; i++)
      begin
         shadow[i] = 8'($urandom());
         wr(adr[i], shadow[i]);
      end
      wr(10'h110, 8'hff);
      for (int i = 0; i < 10; i++)
         rd(adr[i], (shadow[i] & msk[i]) | (rst_v[i] & ~msk[i]));
      rd(10'h110, 8'h00);
      idle(2);
      chk(sync_pattern_o, {shadow[2], shadow[1], shadow[0]});
      chk(channel_tuning_word_o, {shadow[8], shadow[7], shadow[6]});
      chk(tx_deviation_o, shadow[9][5:0]);
      chk({sync_tol_o, sync_len_o}, shadow[3][6:0]);
      // every format code, with skip-sync and gain lock both requested
      wr(10'h111, 8'h6b);
      wr(10'h10f, 8'h18);
      for (int f = 0; f < 6; f++)
      begin
         wr(10'h13e, 8'(f));
         idle(2);
         chk(frame_format_code_o, 8'(f));
         chk({fsk_mode_o, agc_lock_after_preamble_o, sync_detect_en_o}, {f > 2 && f < 5, f > 2 && f < 5, f != 3});
      end
      // every preamble level, then detection bypassed
      for (int l = 0; l < 16; l++)
      begin
         wr(10'h111, 8'(l));
         idle(2);
         chk({preamble_qual_en_o, preamble_err_allow_o}, {l != 0, (l > 0 && l < 12) ? 4'(12 - l) : 4'h0});
      end
      wr(10'h111, 8'h1c);
      idle(2);
      chk({preamble_detect_en_o, preamble_qual_en_o}, 2'b00);
      wr(10'h10f, 8'h60);
      idle(2);
      chk({sync_tol_o, sync_len_o, sync_detect_en_o}, {2'h3, 5'h00, 1'b0});
      // recommended deviation settings read back and reach the transmitter unchanged
      foreach (dev_rec[i])
      begin
         wr(10'h304, dev_rec[i]);
         rd(10'h304, dev_rec[i]);
         idle(2);
         chk(tx_deviation_o, dev_rec[i][5:0]);
      end
      // reset in mid-run brings registers and decoded controls back to their defaults
      wr(10'h13e, 8'h04);
      idle(2);
      rst_i = 1'b1;
      idle(2);
      rst_i = 1'b0;
      rd(10'h13e, 8'h00);
      rd(10'h304, 8'h32);
      idle(2);
      chk({fsk_mode_o, sync_detect_en_o, preamble_err_allow_o}, {2'b01, 4'h1});
      chk(sync_pattern_o, 24'haa7a31);
      idle(3);
      chk(24'(exp_q.size()), 24'h0);
      end_of_test();
   end
   // the whole run takes about 155 cycles; this limit of 2000 cycles is far beyond it
   initial
   begin
      #200000;
      n_mismatch++;
      end_of_test();
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
endmodule
`default_nettype wire

// File: core/rscr_pkg.sv
// register map, field layout and reset values of the sync, preamble, format and channel registers
// assumes a byte-wide register port with 10-bit addresses driven by the device's host interface logic
package rscr_pkg;
   // register offsets
   localparam logic [9:0] SYNC_PATTERN_LOW_ADDR = 10'h10c;
   localparam logic [9:0] SYNC_PATTERN_MID_ADDR = 10'h10d;
   localparam logic [9:0] SYNC_PATTERN_HIGH_ADDR = 10'h10e;
   localparam logic [9:0] SYNC_MATCH_SETUP_ADDR = 10'h10f;
   localparam logic [9:0] PREAMBLE_DETECT_SETUP_ADDR = 10'h111;
   localparam logic [9:0] PACKET_FORMAT_SELECT_ADDR = 10'h13e;
   localparam logic [9:0] CHANNEL_TUNING_LOW_ADDR = 10'h300;
   localparam logic [9:0] CHANNEL_TUNING_MID_ADDR = 10'h301;
   localparam logic [9:0] CHANNEL_TUNING_HIGH_ADDR = 10'h302;
   localparam logic [9:0] TRANSMIT_DEVIATION_SETTING_ADDR = 10'h304;
   // reset values
   localparam logic [7:0] SYNC_PATTERN_LOW_RST = 8'h31;
   localparam logic [7:0] SYNC_PATTERN_MID_RST = 8'h7a;
   localparam logic [7:0] SYNC_PATTERN_HIGH_RST = 8'haa;
   localparam logic [7:0] SYNC_MATCH_SETUP_RST = 8'h18;
   localparam logic [7:0] PREAMBLE_DETECT_SETUP_RST = 8'h0b;
   localparam logic [7:0] PACKET_FORMAT_SELECT_RST = 8'h00;
   localparam logic [7:0] CHANNEL_TUNING_LOW_RST = 8'h80;
   localparam logic [7:0] CHANNEL_TUNING_MID_RST = 8'ha9;
   localparam logic [7:0] CHANNEL_TUNING_HIGH_RST = 8'h03;
   localparam logic [7:0] TRANSMIT_DEVIATION_SETTING_RST = 8'h32;
   // writable masks; reserved bits hold their reset value
   localparam logic [7:0] SYNC_MATCH_SETUP_WMASK = 8'h7f;
   localparam logic [7:0] PREAMBLE_DETECT_SETUP_WMASK = 8'h7f;
   localparam logic [7:0] TRANSMIT_DEVIATION_SETTING_WMASK = 8'h3f;
   // field positions
   localparam int SYNC_TOL_MSB = 6;
   localparam int SYNC_TOL_LSB = 5;
   localparam int SYNC_LEN_MSB = 4;
   localparam int SKIP_SYNC_BIT = 6;
   localparam int AGC_LOCK_BIT = 5;
   localparam int SKIP_PREAMBLE_BIT = 4;
   localparam int PREAMBLE_LEVEL_MSB = 3;
   localparam int TX_DEV_MSB = 5;
   // field limits
   localparam logic [4:0] SYNC_LEN_MAX = 5'h18;
   localparam logic [3:0] PREAMBLE_LEVEL_MAX = 4'hc;
   // frame format codes
   localparam logic [7:0] FMT_PKT_154 = 8'h00;
   localparam logic [7:0] FMT_RX_STREAM_154 = 8'h02;
   localparam logic [7:0] FMT_FSK_STREAM = 8'h03;
   localparam logic [7:0] FMT_FSK_PKT = 8'h04;
endpackage

// File: core/rscr_regs.sv
// sync pattern, preamble, frame format, channel tuning and transmit deviation register bank
// assumes a synchronous byte register port in the core clock domain (write and read strobes for one cycle)
// the decoded controls feed the correlator, gain control and synthesizer, all on the same core clock
// Summary of operation
// - sync pattern bits 23:16 live in their own byte register, reset 170.
// - sync pattern bits 15:8 and 7:0 come from two more byte registers, the full pattern is the three bytes joined.
// - bits 6:5 of the sync match setup give the number of bit errors, 0 to 3, allowed in a sync match.
// - bits 4:0 of the sync match setup, reset 24, give the compared pattern length; 0 disables detection, 25-31 reserved.
// - preamble setup bit 6 set skips sync detection, only in the fsk serial-stream format.
// - preamble setup bit 5 set freezes gain control after preamble, only in fsk packet or serial-stream formats.
// - preamble setup bit 4 set turns off preamble detection and qualification, searching only for the sync pattern.
// - preamble bits 3:0, reset 11, qualify over 12 bit-pairs: 0xc allows no errors, each lower code one more, 0 disables.
// - an 8-bit frame format code selects 15.4 packet (0), 15.4 receive stream (2), fsk stream (3) or fsk packet (4).
// - the channel is a 24-bit tuning word in 10 kHz units, split into low, middle and high bytes.
// - transmit deviation bits 5:0, reset 50, give deviation in 10 kHz steps; bits 7:6 reserved.
`timescale 1ns/100ps
`default_nettype none
module rscr_regs
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic wr_en_i,
   input wire logic rd_en_i,
   input wire logic [9:0] addr_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o,
   output logic rd_valid_o,
   output logic [23:0] sync_pattern_o,
   output logic [4:0] sync_len_o,
   output logic [1:0] sync_tol_o,
   output logic sync_detect_en_o,
   output logic preamble_detect_en_o,
   output logic preamble_qual_en_o,
   output logic [3:0] preamble_err_allow_o,
   output logic agc_lock_after_preamble_o,
   output logic [7:0] frame_format_code_o,
   output logic fsk_mode_o,
   output logic [23:0] channel_tuning_word_o,
   output logic [5:0] tx_deviation_o
);
   // host-visible byte registers and their next values
   logic [7:0] sync_low_ff, sync_mid_ff, sync_high_ff, sync_match_ff, preamble_ff, format_ff;
   logic [7:0] chan_low_ff, chan_mid_ff, chan_high_ff, tx_dev_ff;
   logic [7:0] nxt_sync_low, nxt_sync_mid, nxt_sync_high, nxt_sync_match, nxt_preamble, nxt_format;
   logic [7:0] nxt_chan_low, nxt_chan_mid, nxt_chan_high, nxt_tx_dev;
   // read port state
   logic [7:0] rdata_ff, nxt_rdata;
   logic rd_valid_ff, nxt_rd_valid;
   // derived controls, registered so every output leaves a flip-flop
   logic [23:0] sync_pattern_ff, chan_word_ff;
   logic [4:0] sync_len_ff;
   logic [1:0] sync_tol_ff;
   logic sync_en_ff, pre_det_ff, pre_qual_ff, agc_lock_ff, fsk_ff;
   logic [3:0] pre_err_ff;
   logic [5:0] tx_out_ff;
   // next values of the derived controls
   logic [23:0] nxt_sync_pattern, nxt_chan_word;
   logic [4:0] nxt_sync_len;
   logic [1:0] nxt_sync_tol;
   logic nxt_sync_en, nxt_pre_det, nxt_pre_qual, nxt_agc_lock, nxt_fsk;
   logic [3:0] nxt_pre_err;
   logic [5:0] nxt_tx_out;

   // register writes; masked fields keep reserved bits at reset
   always_comb
   begin
      // every register keeps its value unless a write hits it
      nxt_sync_low = sync_low_ff;
      nxt_sync_mid = sync_mid_ff;
      nxt_sync_high = sync_high_ff;
      nxt_sync_match = sync_match_ff;
      nxt_preamble = preamble_ff;
      nxt_format = format_ff;
      nxt_chan_low = chan_low_ff;
      nxt_chan_mid = chan_mid_ff;
      nxt_chan_high = chan_high_ff;
      nxt_tx_dev = tx_dev_ff;
      if (wr_en_i)
      begin
         unique case (addr_i)
            rscr_pkg::SYNC_PATTERN_LOW_ADDR: nxt_sync_low = wdata_i;
            rscr_pkg::SYNC_PATTERN_MID_ADDR: nxt_sync_mid = wdata_i;
            rscr_pkg::SYNC_PATTERN_HIGH_ADDR: nxt_sync_high = wdata_i;
            // bit 7 is reserved and rebuilt from its reset value
            rscr_pkg::SYNC_MATCH_SETUP_ADDR:
               nxt_sync_match = (wdata_i & rscr_pkg::SYNC_MATCH_SETUP_WMASK)
                              | (rscr_pkg::SYNC_MATCH_SETUP_RST & ~rscr_pkg::SYNC_MATCH_SETUP_WMASK);
            // bit 7 is reserved; bits 6:0 hold the bypass switches and the match level
            rscr_pkg::PREAMBLE_DETECT_SETUP_ADDR:
               nxt_preamble = (wdata_i & rscr_pkg::PREAMBLE_DETECT_SETUP_WMASK)
                            | (rscr_pkg::PREAMBLE_DETECT_SETUP_RST & ~rscr_pkg::PREAMBLE_DETECT_SETUP_WMASK);
            rscr_pkg::PACKET_FORMAT_SELECT_ADDR: nxt_format = wdata_i;
            rscr_pkg::CHANNEL_TUNING_LOW_ADDR: nxt_chan_low = wdata_i;
            rscr_pkg::CHANNEL_TUNING_MID_ADDR: nxt_chan_mid = wdata_i;
            rscr_pkg::CHANNEL_TUNING_HIGH_ADDR: nxt_chan_high = wdata_i;
            // bits 7:6 are reserved and rebuilt from their reset value
            rscr_pkg::TRANSMIT_DEVIATION_SETTING_ADDR:
               nxt_tx_dev = (wdata_i & rscr_pkg::TRANSMIT_DEVIATION_SETTING_WMASK)
                          | (rscr_pkg::TRANSMIT_DEVIATION_SETTING_RST & ~rscr_pkg::TRANSMIT_DEVIATION_SETTING_WMASK);
            default: ; // unmapped writes are dropped
         endcase
      end
   end

   // register bank; a write lands on the edge that takes it, nothing is held back
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         sync_low_ff <= rscr_pkg::SYNC_PATTERN_LOW_RST;
         sync_mid_ff <= rscr_pkg::SYNC_PATTERN_MID_RST;
         sync_high_ff <= rscr_pkg::SYNC_PATTERN_HIGH_RST;
         sync_match_ff <= rscr_pkg::SYNC_MATCH_SETUP_RST;
         preamble_ff <= rscr_pkg::PREAMBLE_DETECT_SETUP_RST;
         format_ff <= rscr_pkg::PACKET_FORMAT_SELECT_RST;
         chan_low_ff <= rscr_pkg::CHANNEL_TUNING_LOW_RST;
         chan_mid_ff <= rscr_pkg::CHANNEL_TUNING_MID_RST;
         chan_high_ff <= rscr_pkg::CHANNEL_TUNING_HIGH_RST;
         tx_dev_ff <= rscr_pkg::TRANSMIT_DEVIATION_SETTING_RST;
      end
      else
      begin
         sync_low_ff <= nxt_sync_low;
         sync_mid_ff <= nxt_sync_mid;
         sync_high_ff <= nxt_sync_high;
         sync_match_ff <= nxt_sync_match;
         preamble_ff <= nxt_preamble;
         format_ff <= nxt_format;
         chan_low_ff <= nxt_chan_low;
         chan_mid_ff <= nxt_chan_mid;
         chan_high_ff <= nxt_chan_high;
         tx_dev_ff <= nxt_tx_dev;
      end
   end

   // read path: data appears one cycle after the strobe; unmapped reads return zero
   // a read and a write of one address on the same edge return the old value
   always_comb
   begin
      nxt_rd_valid = rd_en_i;
      nxt_rdata = rdata_ff;
      if (rd_en_i)
      begin
         unique case (addr_i)
            rscr_pkg::SYNC_PATTERN_LOW_ADDR: nxt_rdata = sync_low_ff;
            rscr_pkg::SYNC_PATTERN_MID_ADDR: nxt_rdata = sync_mid_ff;
            rscr_pkg::SYNC_PATTERN_HIGH_ADDR: nxt_rdata = sync_high_ff;
            rscr_pkg::SYNC_MATCH_SETUP_ADDR: nxt_rdata = sync_match_ff;
            rscr_pkg::PREAMBLE_DETECT_SETUP_ADDR: nxt_rdata = preamble_ff;
            rscr_pkg::PACKET_FORMAT_SELECT_ADDR: nxt_rdata = format_ff;
            rscr_pkg::CHANNEL_TUNING_LOW_ADDR: nxt_rdata = chan_low_ff;
            rscr_pkg::CHANNEL_TUNING_MID_ADDR: nxt_rdata = chan_mid_ff;
            rscr_pkg::CHANNEL_TUNING_HIGH_ADDR: nxt_rdata = chan_high_ff;
            rscr_pkg::TRANSMIT_DEVIATION_SETTING_ADDR: nxt_rdata = tx_dev_ff;
            default: nxt_rdata = 8'h00;
         endcase
      end
   end

   // rdata holds its last value between reads, so a slow host can still pick it up
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         rdata_ff <= 8'h00;
         rd_valid_ff <= 1'b0;
      end
      else
      begin
         rdata_ff <= nxt_rdata;
         rd_valid_ff <= nxt_rd_valid;
      end
   end

   // sync correlator controls
   // the skip bit is honoured only in the fsk serial-stream format, so a stale
   // setting left over from that mode cannot blind the 15.4 packet search
   always_comb
   begin
      logic is_fsk_stream;
      is_fsk_stream = (format_ff == rscr_pkg::FMT_FSK_STREAM);
      nxt_sync_pattern = {sync_high_ff, sync_mid_ff, sync_low_ff};
      nxt_sync_tol = sync_match_ff[rscr_pkg::SYNC_TOL_MSB:rscr_pkg::SYNC_TOL_LSB];
      nxt_sync_len = sync_match_ff[rscr_pkg::SYNC_LEN_MSB:0];
      // reserved lengths 25-31 are passed on as written; the correlator must cope
      nxt_sync_en = (nxt_sync_len != 5'h00)
                  && !(is_fsk_stream && preamble_ff[rscr_pkg::SKIP_SYNC_BIT]);
   end

   // registered so every correlator control leaves a flip-flop
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         sync_pattern_ff <= {rscr_pkg::SYNC_PATTERN_HIGH_RST, rscr_pkg::SYNC_PATTERN_MID_RST,
                             rscr_pkg::SYNC_PATTERN_LOW_RST};
         sync_tol_ff <= rscr_pkg::SYNC_MATCH_SETUP_RST[rscr_pkg::SYNC_TOL_MSB:rscr_pkg::SYNC_TOL_LSB];
         sync_len_ff <= rscr_pkg::SYNC_MATCH_SETUP_RST[rscr_pkg::SYNC_LEN_MSB:0];
         sync_en_ff <= 1'b1; // reset length is non-zero and format 0 ignores the skip bit
      end
      else
      begin
         sync_pattern_ff <= nxt_sync_pattern;
         sync_tol_ff <= nxt_sync_tol;
         sync_len_ff <= nxt_sync_len;
         sync_en_ff <= nxt_sync_en;
      end
   end

   // preamble search and gain control
   // errored pairs allowed = 12 - code; codes above 0xc are clamped to zero tolerance
   // rather than wrapping, which would otherwise grant a huge tolerance
   always_comb
   begin
      logic is_fsk_any;
      logic [3:0] level;
      // one fsk decode feeds both the gain lock and the fsk flag, so they cannot disagree
      is_fsk_any = (format_ff == rscr_pkg::FMT_FSK_STREAM)
                 || (format_ff == rscr_pkg::FMT_FSK_PKT);
      level = preamble_ff[rscr_pkg::PREAMBLE_LEVEL_MSB:0];
      nxt_agc_lock = is_fsk_any && preamble_ff[rscr_pkg::AGC_LOCK_BIT];
      // skip-preamble is not gated by format: it applies wherever a preamble is searched
      nxt_pre_det = !preamble_ff[rscr_pkg::SKIP_PREAMBLE_BIT];
      nxt_pre_qual = nxt_pre_det && (level != 4'h0);
      if (level >= rscr_pkg::PREAMBLE_LEVEL_MAX)
         nxt_pre_err = 4'h0;
      else if (level == 4'h0)
         nxt_pre_err = 4'h0;
      else
         nxt_pre_err = rscr_pkg::PREAMBLE_LEVEL_MAX - level;
      nxt_fsk = is_fsk_any;
   end

   // registered copies for the gain control and the preamble detector
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         agc_lock_ff <= 1'b0;
         pre_det_ff <= 1'b1;
         pre_qual_ff <= 1'b1;
         pre_err_ff <= 4'h1; // reset level 11 allows one errored pair
         fsk_ff <= 1'b0;
      end
      else
      begin
         agc_lock_ff <= nxt_agc_lock;
         pre_det_ff <= nxt_pre_det;
         pre_qual_ff <= nxt_pre_qual;
         pre_err_ff <= nxt_pre_err;
         fsk_ff <= nxt_fsk;
      end
   end

   // synthesizer and transmitter settings; partial tuning updates show at once,
   // so the host should write the three tuning bytes while the synthesizer is idle
   // reserved deviation bits never reach the transmitter
   always_comb
   begin
      nxt_chan_word = {chan_high_ff, chan_mid_ff, chan_low_ff};
      nxt_tx_out = tx_dev_ff[rscr_pkg::TX_DEV_MSB:0];
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         chan_word_ff <= {rscr_pkg::CHANNEL_TUNING_HIGH_RST, rscr_pkg::CHANNEL_TUNING_MID_RST,
                          rscr_pkg::CHANNEL_TUNING_LOW_RST};
         tx_out_ff <= rscr_pkg::TRANSMIT_DEVIATION_SETTING_RST[rscr_pkg::TX_DEV_MSB:0];
      end
      else
      begin
         chan_word_ff <= nxt_chan_word;
         tx_out_ff <= nxt_tx_out;
      end
   end

   // outputs straight from flip-flops
   // the format code leaves its own register, one cycle ahead of its decodes
   assign rdata_o = rdata_ff;
   assign rd_valid_o = rd_valid_ff;
   assign sync_pattern_o = sync_pattern_ff;
   assign sync_len_o = sync_len_ff;
   assign sync_tol_o = sync_tol_ff;
   assign sync_detect_en_o = sync_en_ff;
   assign preamble_detect_en_o = pre_det_ff;
   assign preamble_qual_en_o = pre_qual_ff;
   assign preamble_err_allow_o = pre_err_ff;
   assign agc_lock_after_preamble_o = agc_lock_ff;
   assign frame_format_code_o = format_ff;
   assign fsk_mode_o = fsk_ff;
   assign channel_tuning_word_o = chan_word_ff;
   assign tx_deviation_o = tx_out_ff;
endmodule
`default_nettype wire
